/* logic/shutdown_consts.vh */
/*
  Shared constants of the shutdown sequencer: register offsets, field layout,
  reset values and timing figures.
  Assumes a 200 MHz sequencer clock; counts derive from the times given here.
*/
`ifndef SHUTDOWN_CONSTS_VH
`define SHUTDOWN_CONSTS_VH

// Clock rate in MHz, used to turn microseconds into cycles
`define CLK_MHZ            200
// Step timebase, microseconds per step
`define TB0_US             30
`define TB1_US             120
`define TB2_US             250
`define TB3_US             500
// Group gap, microseconds
`define GAP0_US            120
`define GAP1_US            250
`define GAP2_US            500
`define GAP3_US            1000
// Host reset lead delay, microseconds (code 0 means none)
`define LEAD1_US           10
`define LEAD2_US           100
`define LEAD3_US           500
// Post-shutdown holdoff, tenths of a millisecond (code 0 means none)
`define HOLD1_TMS          15
`define HOLD2_TMS          50
`define HOLD3_TMS          100
// Register offsets
`define REG_CTRL           8'h00
`define REG_STATUS         8'h01
`define REG_TIMING         8'h02
`define REG_SLOT_BASE      8'h10
`define REG_GROUP_BASE     8'h20
// Control register fields
`define CTRL_ORDER_BIT     0
`define CTRL_GPO_BIT       1
// Status register fields
`define STAT_DONE_BIT      0
`define STAT_BUSY_BIT      1
`define STAT_HOLD_BIT      2
// Timing register fields
`define TIM_TBASE_LSB      0
`define TIM_LEAD_LSB       2
`define TIM_HOLD_LSB       4
// Reset values
`define HOLD_RESET         2'h0
// Shutdown order codes
`define ORDER_SEQ          1'b0
`define ORDER_GROUP        1'b1
// Unused slot code
`define SLOT_NONE          8'h00

`endif

/* logic/power_down_sequencer.v */
/*
  Shutdown sequencer: turns regulator enables, a general-purpose power-ok
  output and the host reset output off in slot order or by groups, then
  masks the power request until a holdoff has passed.
  Assumes fused defaults arrive as steady levels, the regulator count and
  the output order are set by parameters: outputs 0..N-1 are regulators,
  output N is the power-ok pin, output N+1 is the host reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "shutdown_consts.vh"

module power_down_sequencer #(
  parameter N_REG    = 7,
  parameter HOLD3_CY = `HOLD3_TMS * `CLK_MHZ * 100,
  parameter HOLD2_CY = `HOLD2_TMS * `CLK_MHZ * 100,
  parameter HOLD1_CY = `HOLD1_TMS * `CLK_MHZ * 100
) (
  input  wire                 ref_clk,
  input  wire                 rst,
  input  wire [7:0]           reg_addr,
  input  wire [7:0]           reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [7:0]           reg_rdata,
  input  wire                 shutdown_req,
  input  wire                 standby_req,
  input  wire [N_REG-1:0]     standby_keep,
  input  wire                 off_mode,
  input  wire                 hard_watchdog_reset,
  input  wire                 power_request_pin,
  input  wire [1:0]           fused_step_timebase,
  input  wire [8*(N_REG+2)-1:0] fused_slot_codes,
  input  wire [2*(N_REG+2)-1:0] fused_groups,
  input  wire [1:0]           fused_lead_delay,
  input  wire [1:0]           post_shutdown_holdoff,
  input  wire                 fused_shutdown_order,
  output wire [N_REG-1:0]     reg_enable,
  output wire                 power_ok_pin,
  output wire                 host_reset_out,
  output reg                  power_request_ok,
  output reg                  standby_entry_done_flag
);

  localparam NO = N_REG + 2;
  localparam PG = N_REG;
  localparam HR = N_REG + 1;
  localparam [31:0] ST0 = `TB0_US * `CLK_MHZ;
  localparam [31:0] ST1 = `TB1_US * `CLK_MHZ;
  localparam [31:0] ST2 = `TB2_US * `CLK_MHZ;
  localparam [31:0] ST3 = `TB3_US * `CLK_MHZ;
  localparam [31:0] GP0 = `GAP0_US * `CLK_MHZ;
  localparam [31:0] GP1 = `GAP1_US * `CLK_MHZ;
  localparam [31:0] GP2 = `GAP2_US * `CLK_MHZ;
  localparam [31:0] GP3 = `GAP3_US * `CLK_MHZ;
  localparam [31:0] LD1 = `LEAD1_US * `CLK_MHZ;
  localparam [31:0] LD2 = `LEAD2_US * `CLK_MHZ;
  localparam [31:0] LD3 = `LEAD3_US * `CLK_MHZ;

  localparam S_IDLE = 3'h0;
  localparam S_SEQ  = 3'h1;
  localparam S_GRP  = 3'h2;
  localparam S_LEAD = 3'h3;
  localparam S_GAP  = 3'h4;
  localparam S_HOLD = 3'h5;

  // Step timebase in cycles
  function [31:0] tb_cycles;
    input [1:0] code;
    begin
      case (code)
        2'h0:    tb_cycles = ST0;
        2'h1:    tb_cycles = ST1;
        2'h2:    tb_cycles = ST2;
        default: tb_cycles = ST3;
      endcase
    end
  endfunction

  // Group gap in cycles
  function [31:0] gap_cycles;
    input [1:0] code;
    begin
      case (code)
        2'h0:    gap_cycles = GP0;
        2'h1:    gap_cycles = GP1;
        2'h2:    gap_cycles = GP2;
        default: gap_cycles = GP3;
      endcase
    end
  endfunction

  // Host reset lead delay in cycles, zero for none
  function [31:0] lead_cycles;
    input [1:0] code;
    begin
      case (code)
        2'h0:    lead_cycles = 32'h0;
        2'h1:    lead_cycles = LD1;
        2'h2:    lead_cycles = LD2;
        default: lead_cycles = LD3;
      endcase
    end
  endfunction

  // Holdoff in cycles, zero for none
  function [31:0] hold_cycles;
    input [1:0] code;
    begin
      case (code)
        2'h0:    hold_cycles = 32'h0;
        2'h1:    hold_cycles = HOLD1_CY;
        2'h2:    hold_cycles = HOLD2_CY;
        default: hold_cycles = HOLD3_CY;
      endcase
    end
  endfunction

  // Working configuration
  reg [1:0]    step_timebase_r;
  reg [1:0]    lead_r;
  reg [1:0]    hold_r;
  reg          shutdown_order_select_r;
  reg          gpo_mode_r;
  reg [7:0]    slot_code_r [0:NO-1];
  reg [1:0]    shutdown_group_r [0:NO-1];
  reg [1:0]    gap_r [0:3];
  // Sequencer state
  reg [2:0]    state_r;
  reg [31:0]   cnt_r;
  reg [7:0]    cur_slot_r;
  reg [1:0]    cur_grp_r;
  reg [NO-1:0] on_r;
  reg          is_standby_r;
  reg [2:0]    pin_sync_r;
  reg          pin_level_r;

  assign reg_enable     = on_r[N_REG-1:0];
  assign power_ok_pin   = on_r[PG] & gpo_mode_r;
  assign host_reset_out = ~on_r[HR];

  // Per-output match terms for the current slot and group
  wire [NO-1:0] target;
  wire [NO-1:0] slot_hit;
  wire [NO-1:0] zero_hit;
  wire [NO-1:0] grp_hit;
  wire [NO-1:0] above;
  genvar gi;
  generate
    for (gi = 0; gi < NO; gi = gi + 1) begin : g_out
      if (gi < N_REG) begin : g_reg
        assign target[gi] = ~(is_standby_r & standby_keep[gi]);
      end else if (gi == PG) begin : g_pg
        assign target[gi] = gpo_mode_r & ~is_standby_r;
      end else begin : g_hr
        assign target[gi] = ~is_standby_r;
      end
      assign zero_hit[gi] = slot_code_r[gi] == `SLOT_NONE;
      assign slot_hit[gi] = slot_code_r[gi] == cur_slot_r;
      assign grp_hit[gi]  = shutdown_group_r[gi] == cur_grp_r;
      assign above[gi]    = slot_code_r[gi] < cur_slot_r;
    end
  endgenerate

  // Still-on outputs that the shutdown takes down
  wire [NO-1:0] pend     = on_r & target;
  wire          any_pend = |pend;
  wire          grp_hr   = pend[HR] & grp_hit[HR];
  wire [NO-1:0] grp_off  = pend & grp_hit;

  // Highest slot still pending below the current one
  reg [7:0] next_slot;
  integer   k;
  always @* begin
    next_slot = 8'h00;
    for (k = 0; k < NO; k = k + 1) begin
      if (pend[k] && above[k] && slot_code_r[k] > next_slot) begin
        next_slot = slot_code_r[k];
      end
    end
  end

  // Lowest-hierarchy group still holding a pending output
  reg [1:0] next_grp;
  reg       next_grp_ok;
  integer   j;
  always @* begin
    next_grp    = 2'h0;
    next_grp_ok = 1'b0;
    for (j = NO - 1; j >= 0; j = j - 1) begin
      if (pend[j] && (!next_grp_ok || shutdown_group_r[j] < next_grp)) begin
        next_grp    = shutdown_group_r[j];
        next_grp_ok = 1'b1;
      end
    end
  end

  // Power request pin: three-stage synchroniser, accepted on agreement
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_sync_r  <= 3'h0;
      pin_level_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], power_request_pin};
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_level_r <= pin_sync_r[2];
      end
    end
  end

  // Mask the request pin while busy or holding off
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      power_request_ok <= 1'b0;
    end else begin
      power_request_ok <= pin_level_r & (state_r == S_IDLE);
    end
  end

  // Configuration: host writes, fused reload in off mode
  integer i;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      step_timebase_r         <= 2'h0;
      lead_r                  <= 2'h0;
      hold_r                  <= `HOLD_RESET;
      shutdown_order_select_r <= `ORDER_SEQ;
      gpo_mode_r              <= 1'b0;
      for (i = 0; i < NO; i = i + 1) begin
        slot_code_r[i]      <= 8'h00;
        shutdown_group_r[i] <= 2'h0;
      end
      for (i = 0; i < 4; i = i + 1) begin
        gap_r[i] <= 2'h0;
      end
    end else if (off_mode) begin
      step_timebase_r         <= fused_step_timebase;
      lead_r                  <= fused_lead_delay;
      hold_r                  <= post_shutdown_holdoff;
      shutdown_order_select_r <= fused_shutdown_order;
      for (i = 0; i < NO; i = i + 1) begin
        slot_code_r[i]      <= fused_slot_codes[8*i +: 8];
        shutdown_group_r[i] <= fused_groups[2*i +: 2];
      end
    end else if (reg_wr) begin
      if (reg_addr == `REG_CTRL) begin
        shutdown_order_select_r <= reg_wdata[`CTRL_ORDER_BIT];
        gpo_mode_r              <= reg_wdata[`CTRL_GPO_BIT];
      end
      if (reg_addr == `REG_TIMING) begin
        step_timebase_r <= reg_wdata[`TIM_TBASE_LSB +: 2];
        lead_r          <= reg_wdata[`TIM_LEAD_LSB +: 2];
      end
      for (i = 0; i < NO; i = i + 1) begin
        if (reg_addr == `REG_SLOT_BASE + i[7:0]) begin
          slot_code_r[i] <= reg_wdata;
        end
        if (reg_addr == `REG_GROUP_BASE + i[7:0]) begin
          shutdown_group_r[i] <= reg_wdata[1:0];
        end
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (reg_addr == `REG_GROUP_BASE + NO[7:0] + i[7:0]) begin
          gap_r[i] <= reg_wdata[1:0];
        end
      end
    end
  end

  // Sequencer state machine
  integer m;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r                 <= S_IDLE;
      cnt_r                   <= 32'h0;
      cur_slot_r              <= 8'h00;
      cur_grp_r               <= 2'h0;
      on_r                    <= {NO{1'b0}};
      is_standby_r            <= 1'b0;
      standby_entry_done_flag <= 1'b0;
    end else begin
      // Flag clears on a status read; a new set wins
      if (reg_rd && reg_addr == `REG_STATUS) begin
        standby_entry_done_flag <= 1'b0;
      end
      case (state_r)
        S_IDLE: begin
          if (off_mode) begin
            on_r <= {NO{1'b1}};
          end
          if (hard_watchdog_reset || shutdown_req) begin
            is_standby_r <= 1'b0;
            cur_slot_r   <= 8'hFF;
            state_r      <= shutdown_order_select_r ? S_GRP : S_SEQ;
            for (m = 0; m < NO; m = m + 1) begin
              if (zero_hit[m] && !shutdown_order_select_r) begin
                on_r[m] <= 1'b0;
              end
            end
          end else if (standby_req) begin
            is_standby_r <= 1'b1;
            cur_slot_r   <= 8'hFF;
            if (~|(on_r[N_REG-1:0] & ~standby_keep)) begin
              standby_entry_done_flag <= 1'b1;
            end else begin
              state_r <= shutdown_order_select_r ? S_GRP : S_SEQ;
            end
          end
        end
        S_SEQ: begin
          // Drop outputs on current slot, then step to the next lower pending slot
          if (cnt_r != 32'h0) begin
            cnt_r <= cnt_r - 32'h1;
          end else begin
            for (m = 0; m < NO; m = m + 1) begin
              if (pend[m] && (slot_hit[m] || zero_hit[m])) begin
                on_r[m] <= 1'b0;
              end
            end
            if (next_slot == 8'h00) begin
              state_r <= S_HOLD;
              cnt_r   <= is_standby_r ? 32'h0 : hold_cycles(hold_r);
            end else begin
              cur_slot_r <= next_slot;
              cnt_r      <= tb_cycles(step_timebase_r) - 32'h1;
            end
          end
        end
        S_GRP: begin
          if (!any_pend) begin
            state_r <= S_HOLD;
            cnt_r   <= is_standby_r ? 32'h0 : hold_cycles(hold_r);
          end else begin
            cur_grp_r <= next_grp;
            state_r   <= S_LEAD;
            cnt_r     <= 32'h0;
          end
        end
        S_LEAD: begin
          // Host reset first, then the rest of its group; no lead drops all at once
          if (grp_hr && lead_cycles(lead_r) != 32'h0) begin
            on_r[HR] <= 1'b0;
            cnt_r    <= lead_cycles(lead_r);
          end else if (cnt_r != 32'h0) begin
            cnt_r <= cnt_r - 32'h1;
          end else begin
            on_r    <= on_r & ~grp_off;
            state_r <= S_GAP;
            cnt_r   <= gap_cycles(gap_r[cur_grp_r]) - 32'h1;
          end
        end
        S_GAP: begin
          if (cnt_r != 32'h0) begin
            cnt_r <= cnt_r - 32'h1;
          end else begin
            state_r <= S_GRP;
          end
        end
        S_HOLD: begin
          if (cnt_r != 32'h0) begin
            cnt_r <= cnt_r - 32'h1;
          end else begin
            state_r <= S_IDLE;
            if (is_standby_r) begin
              standby_entry_done_flag <= 1'b1;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // Register read mux, data in the cycle after the strobe
  integer r;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
      if (reg_addr == `REG_CTRL) begin
        reg_rdata <= {6'h00, gpo_mode_r, shutdown_order_select_r};
      end
      if (reg_addr == `REG_STATUS) begin
        reg_rdata <= {5'h00, state_r == S_HOLD, state_r != S_IDLE,
                      standby_entry_done_flag};
      end
      if (reg_addr == `REG_TIMING) begin
        reg_rdata <= {2'h0, hold_r, lead_r, step_timebase_r};
      end
      for (r = 0; r < NO; r = r + 1) begin
        if (reg_addr == `REG_SLOT_BASE + r[7:0]) begin
          reg_rdata <= slot_code_r[r];
        end
        if (reg_addr == `REG_GROUP_BASE + r[7:0]) begin
          reg_rdata <= {6'h00, shutdown_group_r[r]};
        end
      end
      for (r = 0; r < 4; r = r + 1) begin
        if (reg_addr == `REG_GROUP_BASE + NO[7:0] + r[7:0]) begin
          reg_rdata <= {6'h00, gap_r[r]};
        end
      end
    end
  end

endmodule

`default_nettype wire

/* tb/pds_chk.sv */
/* Checker on the shutdown sequencer ports.
   Assumes one clock and an active-high reset; bound to every instance. */
`timescale 1ns/1ps
`default_nettype none
module pds_chk #(
  parameter N_REG = 7
) (
  input wire logic             ref_clk,
  input wire logic             rst,
  input wire logic [7:0]       reg_addr,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata,
  input wire logic             standby_req,
  input wire logic [N_REG-1:0] standby_keep,
  input wire logic             off_mode,
  input wire logic [N_REG-1:0] reg_enable,
  input wire logic             power_ok_pin,
  input wire logic             host_reset_out,
  input wire logic             power_request_ok,
  input wire logic             standby_entry_done_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Request masking and output recovery
  AST_HOLD_MASK: assert property ($rose(host_reset_out) |=> !power_request_ok [*8])
    else $error("power request unmasked early");
  AST_ENA_RISE: assert property ((reg_enable & ~$past(reg_enable)) != '0 |-> $past(off_mode))
    else $error("regulator came back outside off mode");
  AST_OFF_ON: assert property (off_mode |=> &reg_enable)
    else $error("off mode did not restore enables");
  AST_RST_STAYS: assert property (host_reset_out && !off_mode |=> host_reset_out)
    else $error("host reset released outside off mode");
  AST_GPO_RISE: assert property ($rose(power_ok_pin) |-> $past(off_mode) || $past(reg_wr))
    else $error("power-ok output rose by itself");
  // Standby handling, done flag and read data
  AST_FLAG_NOW: assert property (standby_req && power_request_ok
    && (reg_enable & ~standby_keep) == '0 |=> standby_entry_done_flag)
    else $error("done flag late on empty standby");
  AST_STBY_HOST: assert property (standby_req && power_request_ok && !host_reset_out
    |=> !host_reset_out [*8])
    else $error("standby touched host reset");
  AST_FLAG_HOLD: assert property ($fell(standby_entry_done_flag)
    |-> ($past(reg_rd) && $past(reg_addr) == 8'h01) || $past(off_mode))
    else $error("done flag cleared without status read");
  AST_RDATA_HOLD: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
endmodule
bind power_down_sequencer pds_chk #(.N_REG(N_REG)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby_req(standby_req),
  .standby_keep(standby_keep), .off_mode(off_mode), .reg_enable(reg_enable),
  .power_ok_pin(power_ok_pin), .host_reset_out(host_reset_out),
  .power_request_ok(power_request_ok), .standby_entry_done_flag(standby_entry_done_flag)
);
`default_nettype wire

/* tb/reg_bank_model.sv */
/* Regulator bank and host pin model: records the clock edge at which each
   output turns off. Assumes outputs 0..N-1 regulators, N power-ok, N+1 host reset. */
`timescale 1ns/1ps
`default_nettype none
module reg_bank_model #(
  parameter N = 4
) (
  input  wire logic         ref_clk,
  input  wire logic [N-1:0] reg_enable,
  input  wire logic         power_ok_pin,
  input  wire logic         host_reset_out,
  output var  logic         power_request_pin,
  output var  int           cyc,
  output var  int           fall_t [N+2]
);
  logic [N+1:0] prev;
  wire logic [N+1:0] on_now = {~host_reset_out, power_ok_pin, reg_enable};
  // Host keeps asking for power
  initial begin
    power_request_pin = 1'b1;
    cyc = 0;
  end
  // Edge count and turn-off edge of each output
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    prev <= on_now;
    for (int k = 0; k < N + 2; k++) begin
      if (prev[k] && !on_now[k]) fall_t[k] <= cyc;
    end
  end
endmodule
`default_nettype wire

/* tb/power_down_sequencer_tb_top.sv */
/* Bench for the shutdown sequencer: registers, standby, slot and group
   order, holdoff. Assumes the checker bind and the regulator bank model. */
`timescale 1ns/1ps
`default_nettype none
module power_down_sequencer_tb_top;
  localparam N = 4;
  localparam T = 6000;     // 30 us step
  localparam LEAD = 2000;  // 10 us
  localparam GAP = 24000;  // 120 us
  localparam HOLD = 20;
  localparam logic [47:0] FZ_SLOT = 48'h000403050500;
  localparam logic [11:0] FZ_GRP = 12'h6A5;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, shutdown_req = 1'b0, standby_req = 1'b0;
  logic off_mode = 1'b0, hard_watchdog_reset = 1'b0, fz_order = 1'b0;
  logic [N-1:0] standby_keep = 4'hF;
  logic [N-1:0] reg_enable;
  logic [7:0] reg_rdata;
  logic [7:0] rv;
  logic power_ok_pin, host_reset_out, power_request_ok, standby_entry_done_flag;
  logic power_request_pin;
  int cyc, t0, rt, i, seed = 50194, bad_count = 0, tests_run = 0;
  int fall_t [N+2];

  power_down_sequencer #(.N_REG(N), .HOLD3_CY(80), .HOLD2_CY(40), .HOLD1_CY(HOLD)) dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shutdown_req(shutdown_req),
    .standby_req(standby_req), .standby_keep(standby_keep), .off_mode(off_mode),
    .hard_watchdog_reset(hard_watchdog_reset), .power_request_pin(power_request_pin),
    .fused_step_timebase(2'h0), .fused_slot_codes(FZ_SLOT), .fused_groups(FZ_GRP),
    .fused_lead_delay(2'h1), .post_shutdown_holdoff(2'h1), .fused_shutdown_order(fz_order),
    .reg_enable(reg_enable), .power_ok_pin(power_ok_pin), .host_reset_out(host_reset_out),
    .power_request_ok(power_request_ok), .standby_entry_done_flag(standby_entry_done_flag));
  reg_bank_model #(.N(N)) bank (.ref_clk(ref_clk), .reg_enable(reg_enable),
    .power_ok_pin(power_ok_pin), .host_reset_out(host_reset_out),
    .power_request_pin(power_request_pin), .cyc(cyc), .fall_t(fall_t));

  // Clock
  initial forever #2.5 ref_clk = ~ref_clk;

  // Compare, bus cycles and stimulus helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  function automatic logic near(input int d, input int e);
    return d >= e && d <= e + 2;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic load;
    @(posedge ref_clk);
    off_mode <= 1'b1;
    repeat (3) @(posedge ref_clk);
    off_mode <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic go(input int k, input logic [N-1:0] kp = 4'hF);
    @(posedge ref_clk);
    standby_keep <= kp;
    if (k == 0) shutdown_req <= 1'b1;
    else if (k == 1) hard_watchdog_reset <= 1'b1;
    else standby_req <= 1'b1;
    @(posedge ref_clk);
    {shutdown_req, hard_watchdog_reset, standby_req} <= 3'b000;
    #1 t0 = cyc;
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
    for (i = 0; i < 60000 && power_request_ok !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    rt = cyc;
    chk(i < 60000, 1);
  endtask
  task automatic close_out;
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    #(5 * 99000);
    bad_count++;
    close_out;
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(8'h00, 8'h00);
    rdc(8'h02, 8'h00);
    rdc(8'h0F, 8'h00);
    load;
    chk(reg_enable, 4'hF);
    rdc(8'h02, 8'h14);
    for (i = 0; i < N + 2; i++) begin
      rv = 8'($random(seed));
      wr(8'h10 + i[7:0], rv);
      rdc(8'h10 + i[7:0], rv);
    end
    load;
    for (i = 0; i < N + 2; i++) rdc(8'h10 + i[7:0], FZ_SLOT[8*i +: 8]);
    go(2);
    rdc(8'h01, 8'h01, 8'h01);
    rdc(8'h01, 8'h00, 8'h01);
    go(2, 4'hE);
    for (i = 0; i < 100 && standby_entry_done_flag !== 1'b1; i++) @(negedge ref_clk);
    chk({host_reset_out, standby_entry_done_flag, reg_enable}, 6'h1E);
    // Slot order shutdown
    load;
    wr(8'h00, 8'h02);
    go(0);
    settle;
    chk(fall_t[5], fall_t[0]);
    chk(fall_t[1] - fall_t[0], 1 + T);
    chk(fall_t[2], fall_t[1]);
    chk(fall_t[4] - fall_t[0], 1 + 2 * T);
    chk(fall_t[3] - fall_t[0], 1 + 3 * T);
    chk(rt - fall_t[3] >= HOLD && rt - fall_t[3] <= HOLD + 8, 1);
    // Group shutdown, groups 0 and 3 empty
    load;
    wr(8'h00, 8'h03);
    go(0);
    settle;
    chk(fall_t[5] - t0 < 4, 1);
    chk(fall_t[0] - fall_t[5], LEAD + 1);
    chk(fall_t[1], fall_t[0]);
    chk(near(fall_t[2] - fall_t[0], GAP), 1);
    chk(fall_t[3], fall_t[2]);
    chk(fall_t[4], fall_t[2]);
    // Watchdog shutdown, one group, no lead
    @(posedge ref_clk);
    fz_order <= 1'b1;
    load;
    rdc(8'h00, 8'h01, 8'h01);
    wr(8'h00, 8'h01);
    wr(8'h02, 8'h30);
    rdc(8'h02, 8'h10);
    for (i = 0; i < N + 2; i++) wr(8'h20 + i[7:0], 8'h03);
    go(1);
    settle;
    chk(fall_t[0], fall_t[5]);
    chk(fall_t[3], fall_t[5]);
    chk(rt - fall_t[5] >= GAP + HOLD && rt - fall_t[5] <= GAP + HOLD + 8, 1);
    close_out;
  end
endmodule
`default_nettype wire
